// ===== hw/acc_pkg.sv
// package: register layout, reset values, modes and carriers for the comparator control block
package acc_pkg;

    // register word offset on the apb bus
    localparam logic [7:0] REG_STATUS_CONTROL = 8'h00;

    // field positions within the 8-bit register
    localparam int unsigned BIT_MODULE_ON      = 7;
    localparam int unsigned BIT_REFERENCE_SEL  = 6;
    localparam int unsigned BIT_EVENT_FLAG     = 5;
    localparam int unsigned BIT_IRQ_ENABLE     = 4;
    localparam int unsigned BIT_COMPARE_RESULT = 3;
    localparam int unsigned BIT_PIN_ENABLE     = 2;
    localparam int unsigned MODE_HI            = 1;
    localparam int unsigned MODE_LO            = 0;

    localparam int unsigned REG_WIDTH = 8;

    // event mode encodings
    localparam logic [1:0] MODE_FALL_A  = 2'h0;
    localparam logic [1:0] MODE_RISE    = 2'h1;
    localparam logic [1:0] MODE_FALL_B  = 2'h2;
    localparam logic [1:0] MODE_EITHER  = 2'h3;

    // reset values
    localparam logic [1:0] RESET_MODE = 2'h0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // configuration carried from the register file to the event logic
    typedef struct packed {
        logic       module_on;
        logic       reference_select;
        logic       event_irq_enable;
        logic       result_pin_enable;
        logic [1:0] event_mode;
    } acc_cfg_t;

    // analog-side signals toward the comparator core
    typedef struct packed {
        logic reference_select;
        logic module_on;
    } acc_core_ctl_t;

endpackage

// ===== hw/acc_edge_detect.sv
// module: synchroniser and edge-event detector for the comparator output
`timescale 1ns/1ps
module acc_edge_detect (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             raw_result,
    input  wire logic             module_on,
    input  wire logic [1:0]       event_mode,
    output logic                  result_sync,
    output logic                  event_pulse
);

    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic armed_q;
    logic rise_w;
    logic fall_w;
    logic hit_w;

    // [R14] two-flop synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= raw_result;
            sync_q <= meta_q;
        end
    end

    // history and arm flag; arming one cycle after enable keeps the enable edge quiet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q  <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            prev_q  <= sync_q;
            armed_q <= module_on;
        end
    end

    // [R10] result polarity, high means plus input above minus
    assign rise_w = sync_q & ~prev_q;
    assign fall_w = ~sync_q & prev_q;

    // [R09] event mode selection
    assign hit_w = (event_mode == acc_pkg::MODE_RISE)   ? rise_w :
                   (event_mode == acc_pkg::MODE_EITHER) ? (rise_w | fall_w) :
                   fall_w;

    // [R15] no events while disabled or just enabled
    assign event_pulse = hit_w & module_on & armed_q;
    assign result_sync = sync_q;

endmodule // acc_edge_detect

// ===== hw/acc_top.sv
// module: apb register file and control logic for the analog comparator
// Functional notes
// [R01] bit 7 turns the comparator function on or off.
// [R02] bit 6 picks plus pin (0) or internal bandgap (1).
// [R03] hardware sets the event flag on a selected compare event.
// [R04] writing one clears the event flag; writing zero leaves it.
// [R05] interrupt asserted while flag set and bit 4 enabled.
// [R06] bit 3 reads the present comparator result.
// [R07] result bit reads zero after reset and while disabled.
// [R08] bit 2 drives the result onto the output pin.
// [R09] mode 00/10 falling, 01 rising, 11 either edge.
// [R10] result high when non-inverting input exceeds inverting input.
// [R11] everything lives in one 8-bit register.
// [R12] in shallow stop the logic keeps running and may wake.
// [R13] after deep stop all fields return to reset state.
// [R14] comparator output passes a two-flop synchroniser first.
// [R15] no edge events while disabled or at enable.
`timescale 1ns/1ps
module acc_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        compare_raw,
    input  wire logic        deep_stop_wake,
    output logic             reference_select,
    output logic             module_on,
    output logic             result_pin,
    output logic             result_pin_oe_n,
    output logic             event_irq
);

    logic                on_q;
    logic                refsel_q;
    logic                flag_q;
    logic                flag_d;
    logic                irqen_q;
    logic                pinen_q;
    logic [1:0]          mode_q;
    logic                pin_q;
    logic                irq_q;
    logic [31:0]         rdata_q;
    logic                result_sync;
    logic                event_pulse;
    logic                sel_reg;
    logic                wr_en;
    logic                rd_en;
    logic                result_view;
    logic [7:0]          reg_view;
    acc_pkg::acc_cfg_t   cfg;

    // apb decode; one-cycle access, no wait states
    assign sel_reg = (paddr == acc_pkg::REG_STATUS_CONTROL);
    assign wr_en   = psel & penable & pwrite & sel_reg & pstrb[0];
    assign rd_en   = psel & penable & ~pwrite & sel_reg;
    assign pready  = 1'b1;
    // unmapped offsets answer with an error
    assign pslverr = psel & penable & ~sel_reg;

    assign cfg.module_on         = on_q;
    assign cfg.reference_select  = refsel_q;
    assign cfg.event_irq_enable  = irqen_q;
    assign cfg.result_pin_enable = pinen_q;
    assign cfg.event_mode        = mode_q;

    acc_edge_detect u_edge (
        .pclk        (pclk),
        .presetn     (presetn),
        .raw_result  (compare_raw),
        .module_on   (cfg.module_on),
        .event_mode  (cfg.event_mode),
        .result_sync (result_sync),
        .event_pulse (event_pulse)
    );

    // [R07] gate result while disabled
    assign result_view = result_sync & on_q;

    // [R11] single 8-bit register image
    assign reg_view[acc_pkg::BIT_MODULE_ON]      = on_q;
    assign reg_view[acc_pkg::BIT_REFERENCE_SEL]  = refsel_q;
    assign reg_view[acc_pkg::BIT_EVENT_FLAG]     = flag_q;
    assign reg_view[acc_pkg::BIT_IRQ_ENABLE]     = irqen_q;
    // [R06] live result readback
    assign reg_view[acc_pkg::BIT_COMPARE_RESULT] = result_view;
    assign reg_view[acc_pkg::BIT_PIN_ENABLE]     = pinen_q;
    assign reg_view[acc_pkg::MODE_HI:acc_pkg::MODE_LO] = mode_q;

    // [R03] set wins over clear; [R04] write one clears only
    assign flag_d = event_pulse |
                    (flag_q & ~(wr_en & pwdata[acc_pkg::BIT_EVENT_FLAG]));

    // [R13] deep stop wake restores reset state
    // [R01] [R02] [R09] control fields written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_q     <= 1'b0;
            refsel_q <= 1'b0;
            irqen_q  <= 1'b0;
            pinen_q  <= 1'b0;
            mode_q   <= acc_pkg::RESET_MODE;
            flag_q   <= 1'b0;
        end else if (deep_stop_wake) begin
            on_q     <= 1'b0;
            refsel_q <= 1'b0;
            irqen_q  <= 1'b0;
            pinen_q  <= 1'b0;
            mode_q   <= acc_pkg::RESET_MODE;
            flag_q   <= 1'b0;
        end else begin
            flag_q <= flag_d;
            if (wr_en) begin
                on_q     <= pwdata[acc_pkg::BIT_MODULE_ON];
                refsel_q <= pwdata[acc_pkg::BIT_REFERENCE_SEL];
                irqen_q  <= pwdata[acc_pkg::BIT_IRQ_ENABLE];
                pinen_q  <= pwdata[acc_pkg::BIT_PIN_ENABLE];
                mode_q   <= pwdata[acc_pkg::MODE_HI:acc_pkg::MODE_LO];
            end
        end
    end

    // registered outputs; irq is a level usable as a wake source in shallow stop
    // [R05] [R12] interrupt level from flag and enable
    // [R08] pin drive from result and enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q   <= 1'b0;
            pin_q   <= 1'b0;
            rdata_q <= acc_pkg::RDATA_ZERO;
        end else begin
            irq_q <= flag_d & irqen_q & ~deep_stop_wake;
            pin_q <= result_view & pinen_q;
            if (rd_en) begin
                rdata_q <= {24'h00_0000, reg_view};
            end else begin
                rdata_q <= acc_pkg::RDATA_ZERO;
            end
        end
    end

    // read data sampled combinationally from the live view for zero-wait apb
    assign prdata           = rd_en ? {24'h00_0000, reg_view} : rdata_q;
    assign event_irq        = irq_q;
    assign result_pin       = pin_q;
    // pin is driven (enable low) only when the pin enable is set
    assign result_pin_oe_n  = ~pinen_q;
    assign reference_select = refsel_q;
    assign module_on        = on_q;

endmodule // acc_top

// ===== dv/acc_core_model.sv
// behavioural comparator core: reference pick and compare
`timescale 1ns/1ps
module acc_core_model #(
    parameter logic [7:0] BANDGAP = 8'h64
) (
    input  wire logic       reference_select,
    input  wire logic [7:0] plus_level,
    input  wire logic [7:0] minus_level,
    output logic            compare_raw
);
    // pick and polarity
    // output runs even while the block is off, so the digital side must mask it
    assign compare_raw = (reference_select ? BANDGAP : plus_level) > minus_level;
endmodule // acc_core_model

// ===== dv/acc_checker.sv
// port-level assertions for the comparator control block
`timescale 1ns/1ps
module acc_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [7:0]  pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        module_on,
    input wire logic        reference_select,
    input wire logic        result_pin,
    input wire logic        result_pin_oe_n,
    input wire logic        event_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // accepted access and accepted write to the one register
    wire acc = psel & penable & (paddr == 8'h00);
    wire wr  = acc & pwrite & pstrb[0];
    a_on_written: assert property (wr |=> module_on == $past(pwdata[7]))
        else $error("module_on differs from written bit");
    a_ref_written: assert property (wr |=> reference_select == $past(pwdata[6]))
        else $error("reference_select differs from written bit");
    a_oe_written: assert property (wr |=> result_pin_oe_n == !$past(pwdata[2]))
        else $error("pin enable differs from written bit");
    a_pin_quiet: assert property (result_pin_oe_n && $past(result_pin_oe_n) |-> !result_pin)
        else $error("result pin high while not enabled");
    a_result_off: assert property (acc && !pwrite && !module_on && $past(!module_on)
        |-> !prdata[3])
        else $error("result bit set while disabled");
    a_irq_masked: assert property (wr && !pwdata[4] |=> ##1 !event_irq)
        else $error("interrupt high while masked");
    a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_bad_addr: assert property (psel && penable && paddr != 8'h00 |-> pslverr)
        else $error("no error on unmapped access");
    cover property (wr && pwdata[7]);
    cover property ($rose(event_irq));
    cover property (!result_pin_oe_n && result_pin);
endmodule // acc_checker
bind acc_top acc_checker i_chk (.*, .pwdata(pwdata[7:0]));

// ===== dv/tb.sv
// randomised self-checking bench for the comparator control block
`timescale 1ns/1ps
module tb;
    logic        pclk, presetn, psel, penable, pwrite, deep_stop_wake, er;
    logic [7:0]  paddr, plus_level, minus_level, lfsr_q;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [1:0]  md;
    logic        pready, pslverr, compare_raw, reference_select, module_on;
    logic        result_pin, result_pin_oe_n, event_irq;
    int          fails, checks_done;
    acc_top        i_dut (.*);
    acc_core_model i_core (.*);
    // free-running bus clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // expected flag for a mode and edge; status byte from flag and result
    function automatic logic hit(input logic [1:0] m, input logic up);
        return up ? m[0] : (m != 2'h1);
    endfunction
    function automatic logic [7:0] st(input logic f, input logic r);
        return {2'h0, f, 1'b0, r, 3'h0};
    endfunction
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one apb transfer; a slave that never answers ends the run
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] s);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (n = 0; pready !== 1'b1; n++) begin
            if (n == 50) begin
                fails++;
                complete_run();
            end
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] d);
        apb(1'b1, 8'h00, d, 4'hF);
    endtask
    task automatic rd_chk(input logic [7:0] m, input logic [7:0] e);
        apb(1'b0, 8'h00, 8'h00, 4'hF);
        check("status", e & m, rd[7:0] & m);
    endtask
    // random plus level above or below minus; six edges cover sync, detect and flag
    task automatic drive(input logic up);
        lfsr_q = lfsr(lfsr_q);
        plus_level <= up ? 8'h81 + {2'h0, lfsr_q[5:0]} : {1'b0, lfsr_q[6:0]};
        repeat (6) @(posedge pclk);
    endtask
    initial begin
        {psel, penable, pwrite, deep_stop_wake, presetn} = 5'h00;
        {paddr, pwdata, pstrb, plus_level} = 52'h0;
        minus_level = 8'h80;
        lfsr_q = 8'h1B;
        fails = 0;
        checks_done = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(8'hFF, 8'h00);
        apb(1'b1, 8'h04, 8'h80, 4'hF);
        check("pslverr", 8'h01, {7'h0, er});
        apb(1'b1, 8'h00, 8'h80, 4'h0);
        check("module_on", 8'h00, {7'h0, module_on});
        $display("test reset and refusal done");
        for (int m = 0; m < 4; m++) begin
            md = m[1:0];
            wr({6'h24, md});
            drive(1'b0);
            wr({6'h2C, md});
            drive(1'b1);
            rd_chk(8'h28, st(hit(md, 1'b1), 1'b1));
            check("irq", {7'h0, hit(md, 1'b1)}, {7'h0, event_irq});
            wr({6'h24, md});
            rd_chk(8'h20, st(hit(md, 1'b1), 1'b0));
            wr({6'h2C, md});
            rd_chk(8'h20, 8'h00);
            drive(1'b0);
            rd_chk(8'h28, st(hit(md, 1'b0), 1'b0));
        end
        $display("test event modes done");
        wr(8'h83);
        drive(1'b1);
        check("irq", 8'h00, {7'h0, event_irq});
        wr(8'h23);
        drive(1'b1);
        rd_chk(8'h28, 8'h00);
        drive(1'b0);
        drive(1'b1);
        wr(8'h93);
        drive(1'b1);
        rd_chk(8'h28, st(1'b0, 1'b1));
        $display("test disable done");
        wr(8'hC0);
        {plus_level, minus_level} <= 16'hFFA0;
        // let the level pass the two-flop synchroniser before reading
        repeat (3) @(posedge pclk);
        rd_chk(8'h08, 8'h00);
        {plus_level, minus_level} <= 16'h0050;
        repeat (3) @(posedge pclk);
        rd_chk(8'h08, 8'h08);
        minus_level <= 8'h80;
        wr(8'h84);
        drive(1'b1);
        check("pin", 8'h02, {6'h0, result_pin, result_pin_oe_n});
        wr(8'h80);
        check("pin_oe_n", 8'h01, {7'h0, result_pin_oe_n});
        wr(8'hD7);
        deep_stop_wake <= 1'b1;
        @(posedge pclk);
        deep_stop_wake <= 1'b0;
        rd_chk(8'hFF, 8'h00);
        $display("test select, pin and deep stop done");
        complete_run();
    end
endmodule // tb
